// ### verilog/sdc_pkg.sv
/*
 * Shared constants, command decoding and timing counts for the synchronous
 * DRAM device-side model: command decode, burst engine, byte mask, banks.
 * Assumes one 50 MHz clock shared with the controller, so pin inputs are
 * already in this clock domain.
 */
package sdc_pkg;
    localparam int DQ_W = 8;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int COL_W = 4;
    localparam int NUM_BANKS = 4;
    localparam int MEM_DEPTH = 64;
    localparam int AP_BIT = 10;
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam logic [2:0] MODE_BL_RST = 3'h2;
    localparam logic [2:0] MODE_CL_RST = 3'h3;
    localparam logic [2:0] CL_THREE = 3'h3;
    // write recovery: one clock plus a fixed delay, rounded up to whole cycles
    localparam int CLK_PERIOD_PS = 20000;
    localparam int WR_DELAY_PS = 7000;
    localparam int WR_CYC_INT = 1 + (WR_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0] WR_CYC = 3'(WR_CYC_INT);

    typedef enum logic [2:0] {
        SDC_NOP, SDC_ACT, SDC_RD, SDC_WR, SDC_BST, SDC_PRE, SDC_REF, SDC_LMR
    } sdc_cmd_e;

    typedef enum logic [1:0] {
        SDC_PWR_WAIT, SDC_ONE_REF, SDC_READY
    } sdc_init_e;

    function automatic sdc_cmd_e sdc_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
        sdc_cmd_e c;
        c = SDC_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h3: c = SDC_ACT;
                3'h5: c = SDC_RD;
                3'h4: c = SDC_WR;
                3'h6: c = SDC_BST;
                3'h2: c = SDC_PRE;
                3'h1: c = SDC_REF;
                3'h0: c = SDC_LMR;
                default: c = SDC_NOP;
            endcase
        end
        return c;
    endfunction : sdc_decode

    function automatic logic [2:0] sdc_burst_last(input logic [2:0] bl);
        logic [2:0] r;
        r = 3'h0;
        case (bl[1:0])
            2'h0: r = 3'h0;
            2'h1: r = 3'h1;
            2'h2: r = 3'h3;
            default: r = 3'h7;
        endcase
        return r;
    endfunction : sdc_burst_last
endpackage : sdc_pkg

// ### verilog/sdc_bank_timer.sv
/*
 * One bank's row-open flag and its automatic precharge timer.
 * Assumes en_i is the suspended-clock enable of the parent and that
 * act_i, pre_i and ap_i are single-cycle strobes already qualified by it.
 */
`timescale 1ns/1ps
module sdc_bank_timer
    import sdc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic act_i,
    input wire logic pre_i,
    input wire logic ap_i,
    output logic open_o
);
    typedef struct packed {
        logic open;
        logic [2:0] cnt;
    } sdc_bank_s;

    sdc_bank_s q, d;

    always_comb begin
        d = q;
        if (en_i && q.cnt != 3'h0) begin
            d.cnt = q.cnt - 3'h1;
            if (q.cnt == 3'h1) begin
                d.open = 1'b0;
            end
        end
        // an activate in the closing cycle wins over the timer
        if (act_i) begin
            d.open = 1'b1;
        end
        if (ap_i) begin
            d.cnt = WR_CYC;
        end
        if (pre_i) begin
            d.open = 1'b0;
            d.cnt = 3'h0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign open_o = q.open;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    AST_AP_LOAD: assert property (ap_i && !pre_i |=> q.cnt == WR_CYC)
        else $error("auto precharge timer not loaded with recovery count");
    AST_AP_CLOSE: assert property (q.cnt == 3'h1 && en_i && !act_i |=> !q.open)
        else $error("bank not closed when recovery count expired");
endmodule : sdc_bank_timer

// ### verilog/sdc_device.sv
/*
 * Device-side synchronous DRAM core: command decode, burst engine with
 * read latency 2 or 3, byte mask for writes and reads, clock suspend,
 * per-bank automatic precharge and the power-up refresh tracker.
 * Assumes the controller runs on ref_clk_i and keeps the spacing it owns.
 */
`timescale 1ns/1ps
module sdc_device
    import sdc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [sdc_pkg::BA_W-1:0] ba_i,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr_i,
    input wire logic dqm_i,
    input wire logic [sdc_pkg::DQ_W-1:0] dq_i,
    output logic [sdc_pkg::DQ_W-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic init_done_o
);
    import sdc_pkg::*;

    typedef struct packed {
        logic cke;
        logic [2:0] cl;
        logic [2:0] bl;
        logic rd_act;
        logic wr_act;
        logic [BA_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic [2:0] left;
        logic ap;
        logic dqm;
        logic [1:0] pipe_v;
        logic [2*DQ_W-1:0] pipe_d;
        logic [DQ_W-1:0] dq;
        logic oe_n;
        sdc_init_e init;
        logic init_done;
    } sdc_dev_s;

    sdc_dev_s q, d;
    logic [DQ_W-1:0] mem [0:MEM_DEPTH-1];

    sdc_cmd_e cmd;
    logic en;
    logic [NUM_BANKS-1:0] bank_open;
    logic [NUM_BANKS-1:0] act_b, pre_b, ap_b;
    logic col_cmd;
    logic beat, beat_rd, beat_wr, beat_last, beat_ap;
    logic [BA_W-1:0] beat_bank;
    logic [COL_W-1:0] beat_col, col_mask;
    logic [2:0] beat_left;
    logic stop_hit;
    logic mem_we;
    logic [DQ_W-1:0] rd_word;
    logic [DQ_W:0] out_sel;

    assign cmd = sdc_decode(cs_n_i, ras_n_i, cas_n_i, we_n_i);
    // the internal clock follows clock enable as it was sampled one edge earlier
    assign en = q.cke;
    assign col_cmd = en && (cmd == SDC_RD || cmd == SDC_WR) && bank_open[ba_i];
    // a precharge to another bank leaves the running burst alone
    assign stop_hit = en && (cmd == SDC_BST ||
                      (cmd == SDC_PRE && (addr_i[AP_BIT] || ba_i == q.bank)));

    always_comb begin
        beat = 1'b0;
        beat_rd = 1'b0;
        beat_wr = 1'b0;
        beat_bank = q.bank;
        beat_col = q.col;
        beat_left = q.left;
        beat_ap = q.ap;
        if (col_cmd) begin
            // a new column command cuts any burst in flight
            beat = 1'b1;
            beat_rd = (cmd == SDC_RD);
            beat_wr = (cmd == SDC_WR);
            beat_bank = ba_i;
            beat_col = addr_i[COL_W-1:0];
            beat_left = sdc_burst_last(q.bl);
            beat_ap = addr_i[AP_BIT];
        end else if (en && !stop_hit && (q.rd_act || q.wr_act)) begin
            beat = 1'b1;
            beat_rd = q.rd_act;
            beat_wr = q.wr_act;
        end
    end

    assign beat_last = beat && beat_left == 3'h0;
    // a masked word is dropped at the array port; the burst address still advances
    assign mem_we = beat_wr && !dqm_i;
    assign rd_word = mem[{beat_bank, beat_col}];
    // sequential wrap inside the burst-aligned block; interleaved order is not offered
    assign col_mask = {1'b0, sdc_burst_last(q.bl)};
    // two read stages cover both latencies; latency two taps the first stage
    assign out_sel = (q.cl == CL_THREE) ? {q.pipe_v[1], q.pipe_d[2*DQ_W-1:DQ_W]}
                                        : {q.pipe_v[0], q.pipe_d[DQ_W-1:0]};

    // read bursts with auto precharge reuse the write recovery timer
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            assign act_b[b] = en && cmd == SDC_ACT && ba_i == BA_W'(b);
            assign pre_b[b] = en && cmd == SDC_PRE && (addr_i[AP_BIT] || ba_i == BA_W'(b));
            assign ap_b[b] = beat_last && beat_ap && beat_bank == BA_W'(b);
            sdc_bank_timer u_bank (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .en_i(en),
                .act_i(act_b[b]),
                .pre_i(pre_b[b]),
                .ap_i(ap_b[b]),
                .open_o(bank_open[b])
            );
        end
    endgenerate

    always_comb begin
        d = q;
        // clock enable is sampled even while suspended, otherwise it could never wake
        d.cke = cke_i;
        if (en) begin
            if (cmd == SDC_LMR) begin
                d.bl = addr_i[MODE_BL_LSB +: 3];
                d.cl = addr_i[MODE_CL_LSB +: 3];
            end
            d.bank = beat_bank;
            d.left = beat_left - 3'h1;
            d.ap = beat_ap;
            d.col = (beat_col & ~col_mask) | ((beat_col + COL_W'(1)) & col_mask);
            d.rd_act = beat_rd && !beat_last;
            d.wr_act = beat_wr && !beat_last;
            if (stop_hit && !col_cmd) begin
                d.rd_act = 1'b0;
                d.wr_act = 1'b0;
            end
            // the mask takes one register stage beside the read pipeline, so it acts two clocks later at either latency
            d.dqm = dqm_i;
            d.pipe_v = {q.pipe_v[0], beat_rd};
            d.pipe_d = {q.pipe_d[DQ_W-1:0], rd_word};
            d.dq = out_sel[DQ_W-1:0];
            d.oe_n = !(out_sel[DQ_W] && !q.dqm);
            // refresh has no array effect here; it only counts toward the wake-up sequence
            case (q.init)
                SDC_PWR_WAIT: begin
                    if (cmd == SDC_REF) begin
                        d.init = SDC_ONE_REF;
                    end
                end
                SDC_ONE_REF: begin
                    if (cmd == SDC_REF) begin
                        d.init = SDC_READY;
                        d.init_done = 1'b1;
                    end
                end
                default: begin
                    d.init = SDC_READY;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.cke <= 1'b1;
            q.bl <= MODE_BL_RST;
            q.cl <= MODE_CL_RST;
            q.oe_n <= 1'b1;
            q.init <= SDC_PWR_WAIT;
        end else begin
            q <= d;
        end
    end

    // the array has no reset; its contents are undefined until written
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            mem[{beat_bank, beat_col}] <= dq_i;
        end
    end

    assign dq_o = q.dq;
    assign dq_oe_n_o = q.oe_n;
    assign init_done_o = q.init_done;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    AST_SUSPEND: assert property (!cke_i |=> !en)
        else $error("clock enable low did not suspend internal clock");
    AST_RESUME: assert property (!en && cke_i |=> en)
        else $error("clock enable high did not resume internal clock");
    AST_COL_EACH: assert property (col_cmd && sdc_burst_last(q.bl) != 3'h0
                                   |=> (q.rd_act || q.wr_act) && q.bank == $past(ba_i))
        else $error("back-to-back column command not accepted");
    AST_WMASK: assert property (beat_wr && dqm_i |-> !mem_we)
        else $error("masked write word was stored");
    AST_WFIRST: assert property (col_cmd && cmd == SDC_WR && !dqm_i
                                 |-> mem_we && beat_col == addr_i[COL_W-1:0])
        else $error("first write word not taken with the write command");
    AST_RMASK: assert property (en && dqm_i ##1 en |=> dq_oe_n_o)
        else $error("read mask did not turn outputs off two clocks later");
    AST_PRE_OFF3: assert property (stop_hit && cmd == SDC_PRE && !col_cmd && q.cl == CL_THREE
                                   ##1 (en && !col_cmd) [*2] |=> dq_oe_n_o)
        else $error("outputs still on three clocks after precharge");
    AST_PRE_OFF2: assert property (stop_hit && cmd == SDC_PRE && !col_cmd && q.cl != CL_THREE
                                   ##1 (en && !col_cmd) |=> dq_oe_n_o)
        else $error("outputs still on two clocks after precharge");
    AST_SUSP_HOLD: assert property (!en |=> $stable(dq_oe_n_o) && $stable(dq_o))
        else $error("outputs changed while the internal clock was suspended");
    AST_INIT_DONE: assert property (en && cmd == SDC_REF && q.init == SDC_ONE_REF |=> init_done_o)
        else $error("second wake-up refresh did not mark the device ready");
    AST_AP_ARM: assert property (beat_last && beat_ap && !pre_b[beat_bank]
                                 |=> bank_open[$past(beat_bank)])
        else $error("bank closed before write recovery elapsed");
endmodule : sdc_device

// ### sim/sdc_ctrl_model.sv
/*
 * Controller-side model that drives the command, mask and data pins of the device.
 * Assumes one caller at a time, always called just after a rising edge.
 */
`timescale 1ns/1ps
module sdc_ctrl_model
    import sdc_pkg::*;
(
    input wire logic ref_clk_i,
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [sdc_pkg::BA_W-1:0] ba_o,
    output logic [sdc_pkg::ADDR_W-1:0] addr_o,
    output logic dqm_o,
    output logic [sdc_pkg::DQ_W-1:0] dq_o
);
    logic [3:0] enc [8] = '{4'h7, 4'h3, 4'h5, 4'h4, 4'h6, 4'h2, 4'h1, 4'h0};
    int now = 0;
    int last_wr = -10;
    int last_lmr = -10;
    int bl = 4;

    initial begin
        cke_o = 1'b1;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
        ba_o = '0;
        addr_o = '0;
        dqm_o = 1'b0;
        dq_o = 8'h5a;
    end

    always @(posedge ref_clk_i) begin
        now <= now + 1;
    end

    task automatic step(input logic [3:0] p, input int b, input int a, input logic m, input int d,
                        input logic drv);
        @(posedge ref_clk_i);
        #1;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = p;
        ba_o = b[1:0];
        addr_o = a[12:0];
        dqm_o = m;
        // a released data bus must not keep showing the last word
        dq_o = drv ? d[7:0] : ~dq_o;
    endtask : step

    // inserts idle cycles until the spacings owed after the last write and the last mode register load have run out
    task automatic issue(input sdc_cmd_e c, input int b, input int a, input logic m, input int d,
                         output int at);
        int need;
        need = 0;
        if (c inside {SDC_RD, SDC_WR, SDC_BST}) need = last_wr + 1;
        if (c == SDC_PRE) need = last_wr + 2;
        if (c == SDC_ACT) need = last_wr + 4;
        if (c inside {SDC_ACT, SDC_REF} && last_lmr + 2 > need) need = last_lmr + 2;
        while (now + 2 < need) step(4'h7, 0, 0, 1'b0, 0, 1'b0);
        step(enc[int'(c)], b, a, m, d, c == SDC_WR);
        at = now + 1;
        if (c == SDC_WR) last_wr = at + bl - 1;
        if (c == SDC_LMR) begin
            last_lmr = at;
            bl = 1 << a[1:0];
        end
    endtask : issue
endmodule : sdc_ctrl_model

// ### sim/sdc_device_bench.sv
/*
 * Self-checking bench: an associative array keyed by edge count predicts every read word per edge.
 * Assumes the controller model drives every pin except clock and reset, and counts clock edges.
 */
`timescale 1ns/1ps
module sdc_device_bench;
    import sdc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe_n_o, init_done_o;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_w, dq_o;
    logic [7:0] rnd = 8'h2f;
    int mismatches = 0;
    int n_compared = 0;
    int exp_q[int];
    int mem[int];
    int at_n, cl, i;
    localparam int PWR_WAIT_CYC = 5000; // 100 us of 20 ns clocks
    localparam int TIMEOUT_CYC = PWR_WAIT_CYC + 1000;

    sdc_ctrl_model ctrl (.ref_clk_i(ref_clk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .dqm_o(dqm), .dq_o(dq_w));
    sdc_device DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n),
        .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .dqm_i(dqm), .dq_i(dq_w),
        .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .init_done_o(init_done_o));

    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic finish_test;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic go(input sdc_cmd_e c, input int b, input int a, input logic m, input int d);
        ctrl.issue(c, b, a, m, d, at_n);
    endtask : go

    task automatic wr(input int col, input logic m);
        rnd = lfsr(rnd);
        go(SDC_WR, 1, col, m, rnd);
        if (!m) mem[16 + col % 16] = rnd;
    endtask : wr

    task automatic rd(input int col, input int n, input logic m);
        go(SDC_RD, 1, col, m, 0);
        for (int k = 0; k < n; k++) begin
            if (!m) exp_q[at_n + k + cl - 1] = mem[16 + col + k];
        end
    endtask : rd

    // every edge: a predicted word must be driven, otherwise the bus must be off
    always @(posedge ref_clk_i) begin
        #2;
        if (!rst_i && exp_q.exists(ctrl.now)) begin
            check(dq_oe_n_o, 8'h00);
            check(dq_o, 8'(exp_q[ctrl.now]));
        end else if (!rst_i) begin
            check(dq_oe_n_o, 8'h01);
        end
    end

    always @(posedge ref_clk_i) begin
        if (ctrl.now > TIMEOUT_CYC) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        cl = 2;
        repeat (10) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        check(init_done_o, 8'h00);
        repeat (PWR_WAIT_CYC) go(SDC_NOP, 0, 0, 1'b0, 0);
        go(SDC_REF, 0, 0, 1'b0, 0);
        go(SDC_REF, 0, 0, 1'b0, 0);
        check(init_done_o, 8'h00);
        go(SDC_NOP, 0, 0, 1'b0, 0);
        check(init_done_o, 8'h01);
        go(SDC_LMR, 0, 'h20, 1'b0, 0);
        go(SDC_ACT, 1, 0, 1'b0, 0);
        for (i = 0; i < 4; i++) wr(i, 1'b0);
        wr(2, 1'b1);
        for (i = 0; i < 4; i++) rd(i, 1, i == 1);
        // auto precharge closes the bank, so the next read is refused
        wr('h405, 1'b0);
        repeat (4) go(SDC_NOP, 0, 0, 1'b0, 0);
        go(SDC_RD, 1, 5, 1'b0, 0);
        go(SDC_ACT, 1, 0, 1'b0, 0);
        rd(5, 1, 1'b0);
        repeat (3) go(SDC_NOP, 0, 0, 1'b0, 0);
        ctrl.cke_o = 1'b0;
        go(SDC_RD, 1, 0, 1'b0, 0);
        ctrl.cke_o = 1'b1;
        rd(0, 1, 1'b0);
        repeat (4) go(SDC_NOP, 0, 0, 1'b0, 0);
        go(SDC_PRE, 0, 'h400, 1'b0, 0);
        go(SDC_LMR, 0, 'h32, 1'b0, 0);
        cl = 3;
        go(SDC_ACT, 1, 0, 1'b0, 0);
        rd(0, 2, 1'b0);
        go(SDC_NOP, 0, 0, 1'b0, 0);
        go(SDC_PRE, 1, 0, 1'b0, 0);
        repeat (6) go(SDC_NOP, 0, 0, 1'b0, 0);
        // burst stop drains the fetched words just as a precharge does
        go(SDC_ACT, 1, 0, 1'b0, 0);
        rd(2, 2, 1'b0);
        go(SDC_NOP, 0, 0, 1'b0, 0);
        go(SDC_BST, 0, 0, 1'b0, 0);
        repeat (4) go(SDC_NOP, 0, 0, 1'b0, 0);
        go(SDC_PRE, 0, 'h400, 1'b0, 0);
        go(SDC_LMR, 0, 'h21, 1'b0, 0);
        cl = 2;
        go(SDC_ACT, 1, 0, 1'b0, 0);
        rd(0, 1, 1'b0);
        go(SDC_PRE, 1, 0, 1'b0, 0);
        repeat (4) go(SDC_NOP, 0, 0, 1'b0, 0);
        finish_test();
    end
endmodule : sdc_device_bench
